// ---- sad_top.sv ----
`timescale 1ns/1ns
// How it works
// - Sum triggered records index by index
// - Read finished record during next acquisition
// - Record ready right after last record of a sequence
// - No dead time between sequences
// - Gap between records limited to re-arm
// - Abort discards the partial record
// - Sequences repeat until host stops
// - Averages per sequence at least four in combined mode
// - Record length limited only by memory
// - Decimation ratios one to thirty-two
// - Decimation same in both modes
// - Optional polarity inversion of samples
// - Inversion precedes accumulation stages
// - Inversion available in both modes
module sad_top
  import sad_pkg::*;
#(
  parameter int REC_LEN_W = sad_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sample_valid_i,
  input wire logic [sad_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic trigger_i,
  input wire logic sample_invert_enable_i,
  input wire logic [sad_pkg::DECIM_SEL_W-1:0] decim_sel_i,
  input wire logic averaging_option_i,
  input wire logic simultaneous_readout_option_i,
  input wire logic [REC_LEN_W-1:0] record_len_m1_i,
  input wire logic [sad_pkg::AVG_CNT_W-1:0] num_averages_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic abort_i,
  input wire logic rd_req_i,
  output logic running_o,
  output logic config_error_o,
  output logic rec_ready_o,
  output logic rd_valid_o,
  output logic [sad_pkg::ACC_W-1:0] rd_data_o,
  output logic rd_last_o,
  output logic [sad_pkg::AVG_CNT_W-1:0] records_done_o,
  output logic overrun_o
);
  // ------------------------------------------------------------
  // Front end: inversion and decimation
  // ------------------------------------------------------------
  logic dec_valid;
  logic [SAMPLE_W-1:0] dec_sample;

  sad_front u_front (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sample_valid_i(sample_valid_i),
    .sample_i(sample_i),
    .sample_invert_enable_i(sample_invert_enable_i),
    .decim_sel_i(decim_sel_i),
    .out_valid_o(dec_valid),
    .out_sample_o(dec_sample)
  );

  // ------------------------------------------------------------
  // Two-bank accumulation memory
  // ------------------------------------------------------------
  // Bank bit is the address MSB so one memory holds both banks
  // Sequences loop with no count cap; only memory bounds a record
  logic wr_en;
  logic [REC_LEN_W:0] wr_addr;
  logic [ACC_W-1:0] wr_data;
  logic [REC_LEN_W:0] acc_rd_addr;
  logic [ACC_W-1:0] acc_rd_data;
  logic [REC_LEN_W:0] out_rd_addr;
  logic [ACC_W-1:0] out_rd_data;

  // Accumulate port: read-modify-write on the fill bank
  sad_ram #(.WIDTH(ACC_W), .DEPTH_W(REC_LEN_W + 1)) u_acc_ram (
    .clk_i(clk_i),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data),
    .rd_addr_i(acc_rd_addr),
    .rd_data_o(acc_rd_data)
  );

  // Mirror copy so readout has its own read port
  sad_ram #(.WIDTH(ACC_W), .DEPTH_W(REC_LEN_W + 1)) u_out_ram (
    .clk_i(clk_i),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data),
    .rd_addr_i(out_rd_addr),
    .rd_data_o(out_rd_data)
  );

  // ------------------------------------------------------------
  // Accumulation control
  // ------------------------------------------------------------
  sad_state_type state;
  sad_state_type next_state;
  logic fill_bank;
  logic next_fill_bank;
  logic [REC_LEN_W-1:0] idx;
  logic [REC_LEN_W-1:0] next_idx;
  logic [AVG_CNT_W-1:0] avg_cnt;
  logic [AVG_CNT_W-1:0] next_avg_cnt;
  logic [1:0] rearm_cnt;
  logic [1:0] next_rearm_cnt;
  logic rd_busy;
  logic cfg_ok;
  logic stop_pend;
  logic next_stop_pend;
  logic next_running;
  logic next_config_error;
  logic seq_done;
  logic next_overrun;
  logic [AVG_CNT_W-1:0] next_records_done;
  logic [1:0] pipe_v;
  logic [REC_LEN_W-1:0] pipe_idx [0:1];
  logic [SAMPLE_W-1:0] pipe_s [0:1];
  logic pipe_first [0:1];
  logic pipe_bank [0:1];

  // Too few averages refused in combined mode
  assign cfg_ok = !(averaging_option_i && simultaneous_readout_option_i &&
                    num_averages_i < MIN_AVERAGES);

  // State, bank and counters of the accumulation sequence
  always_comb begin
    next_state = state;
    next_fill_bank = fill_bank;
    next_idx = idx;
    next_avg_cnt = avg_cnt;
    next_rearm_cnt = rearm_cnt;
    next_stop_pend = stop_pend | stop_i;
    next_running = running_o;
    next_config_error = config_error_o;
    next_records_done = records_done_o;
    next_overrun = overrun_o;
    seq_done = 1'b0;
    case (state)
      SAD_IDLE: begin
        next_stop_pend = 1'b0;
        if (start_i) begin
          if (cfg_ok) begin
            next_state = SAD_WAIT;
            next_running = 1'b1;
            next_config_error = 1'b0;
            next_avg_cnt = '0;
            next_records_done = '0;
            next_overrun = 1'b0;
          end else begin
            next_config_error = 1'b1;
          end
        end
      end
      SAD_WAIT: begin
        if (trigger_i) begin
          next_state = SAD_ACC;
          next_idx = '0;
        end
      end
      SAD_ACC: begin
        if (dec_valid) begin
          if (idx == record_len_m1_i) begin
            next_idx = '0;
            next_rearm_cnt = 2'(REARM_CYCLES - 1);
            next_state = SAD_REARM;
            if (avg_cnt + 1'b1 >= num_averages_i) begin
              // Swap banks at once, no readout pause
              seq_done = 1'b1;
              next_avg_cnt = '0;
              next_fill_bank = ~fill_bank;
              next_records_done = records_done_o + 1'b1;
              // Previous record still unread: flag lost data
              if (rec_ready_o || rd_busy) begin
                next_overrun = 1'b1;
              end
            end else begin
              next_avg_cnt = avg_cnt + 1'b1;
            end
          end else begin
            next_idx = idx + 1'b1;
          end
        end
      end
      SAD_REARM: begin
        if (rearm_cnt == '0) begin
          // Stop only between sequences; otherwise loop forever
          if (stop_pend && avg_cnt == '0) begin
            next_state = SAD_IDLE;
            next_running = 1'b0;
          end else begin
            next_state = SAD_WAIT;
          end
        end else begin
          next_rearm_cnt = rearm_cnt - 1'b1;
        end
      end
      default: next_state = SAD_IDLE;
    endcase
    // Abort drops the partial record and its bank
    if (abort_i) begin
      next_state = SAD_IDLE;
      next_running = 1'b0;
      next_avg_cnt = '0;
      next_idx = '0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= SAD_IDLE;
      fill_bank <= 1'b0;
      idx <= '0;
      avg_cnt <= '0;
      rearm_cnt <= '0;
      stop_pend <= 1'b0;
      running_o <= 1'b0;
      config_error_o <= 1'b0;
      records_done_o <= '0;
      overrun_o <= 1'b0;
    end else begin
      state <= next_state;
      fill_bank <= next_fill_bank;
      idx <= next_idx;
      avg_cnt <= next_avg_cnt;
      rearm_cnt <= next_rearm_cnt;
      stop_pend <= next_stop_pend;
      running_o <= next_running;
      config_error_o <= next_config_error;
      records_done_o <= next_records_done;
      overrun_o <= next_overrun;
    end
  end

  // ------------------------------------------------------------
  // Read-modify-write pipeline
  // ------------------------------------------------------------
  // Stage 0 reads, stage 1 adds the held word; the RAM output moves on
  // with the index, so the read word is kept for the add
  logic acc_take;
  logic [ACC_W-1:0] acc_rd_q;
  assign acc_take = (state == SAD_ACC) && dec_valid && !abort_i;
  assign acc_rd_addr = {fill_bank, idx};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pipe_v <= '0;
      pipe_idx[0] <= '0;
      pipe_idx[1] <= '0;
      pipe_s[0] <= '0;
      pipe_s[1] <= '0;
      pipe_first[0] <= 1'b0;
      pipe_first[1] <= 1'b0;
      pipe_bank[0] <= 1'b0;
      pipe_bank[1] <= 1'b0;
      acc_rd_q <= '0;
    end else begin
      pipe_v <= {pipe_v[0], acc_take};
      pipe_idx[0] <= idx;
      pipe_idx[1] <= pipe_idx[0];
      pipe_s[0] <= dec_sample;
      pipe_s[1] <= pipe_s[0];
      pipe_first[0] <= (avg_cnt == '0);
      pipe_first[1] <= pipe_first[0];
      pipe_bank[0] <= fill_bank;
      pipe_bank[1] <= pipe_bank[0];
      acc_rd_q <= acc_rd_data;
    end
  end

  // First record of a sequence overwrites stale bank contents
  assign wr_en = pipe_v[1];
  assign wr_addr = {pipe_bank[1], pipe_idx[1]};
  assign wr_data = pipe_first[1] ? ACC_W'(pipe_s[1])
                 : acc_rd_q + ACC_W'(pipe_s[1]);

  // ------------------------------------------------------------
  // Readout of the finished bank
  // ------------------------------------------------------------
  logic next_rd_busy;
  logic next_rec_ready;
  logic drain_bank;
  logic next_drain_bank;
  logic [REC_LEN_W-1:0] rd_idx;
  logic [REC_LEN_W-1:0] next_rd_idx;
  logic rd_issue;
  logic rd_issue_last;
  logic next_rd_valid;
  logic next_rd_last;

  // Readout runs while the other bank fills
  always_comb begin
    next_rec_ready = rec_ready_o;
    next_rd_busy = rd_busy;
    next_drain_bank = drain_bank;
    next_rd_idx = rd_idx;
    rd_issue = 1'b0;
    if (rd_busy) begin
      rd_issue = 1'b1;
      if (rd_idx == record_len_m1_i) begin
        next_rd_busy = 1'b0;
      end else begin
        next_rd_idx = rd_idx + 1'b1;
      end
    end else if (rec_ready_o && rd_req_i) begin
      next_rec_ready = 1'b0;
      next_rd_busy = 1'b1;
      next_rd_idx = '0;
    end
    // Set wins over consumption; last write lands two cycles after the swap, into the old bank
    if (seq_done && !abort_i) begin
      next_rec_ready = 1'b1;
      next_drain_bank = fill_bank;
    end
    if (abort_i) begin
      next_rec_ready = rec_ready_o & !rd_req_i;
    end
  end

  assign rd_issue_last = rd_issue && (rd_idx == record_len_m1_i);
  assign out_rd_addr = {drain_bank, rd_idx};
  assign next_rd_valid = rd_issue;
  assign next_rd_last = rd_issue_last;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rec_ready_o <= 1'b0;
      rd_busy <= 1'b0;
      drain_bank <= 1'b0;
      rd_idx <= '0;
      rd_valid_o <= 1'b0;
      rd_last_o <= 1'b0;
    end else begin
      rec_ready_o <= next_rec_ready;
      rd_busy <= next_rd_busy;
      drain_bank <= next_drain_bank;
      rd_idx <= next_rd_idx;
      rd_valid_o <= next_rd_valid;
      rd_last_o <= next_rd_last;
    end
  end

  // Memory read data already registered; its valid is registered on the same edge
  assign rd_data_o = out_rd_data;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ready_on_done: assert property (@(posedge clk_i) disable iff (reset_i)
    seq_done && !abort_i |=> rec_ready_o)
    else $error("finished record not offered");
  a_abort_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    abort_i |=> state == SAD_IDLE && !running_o ##1 !wr_en)
    else $error("abort did not drop accumulation");
  a_rearm_gap: assert property (@(posedge clk_i) disable iff (reset_i)
    state == SAD_REARM && !abort_i |-> ##[1:2] state != SAD_REARM)
    else $error("re-arm gap too long");
  a_bank_swap: assert property (@(posedge clk_i) disable iff (reset_i)
    seq_done |=> fill_bank != $past(fill_bank))
    else $error("banks did not alternate");
  a_min_avg: assert property (@(posedge clk_i) disable iff (reset_i)
    state == SAD_IDLE && start_i && !abort_i && !cfg_ok
    |=> state == SAD_IDLE && config_error_o)
    else $error("too few averages accepted");
  a_continuous: assert property (@(posedge clk_i) disable iff (reset_i)
    seq_done && !stop_pend && !stop_i && !abort_i
    |=> running_o ##2 running_o)
    else $error("acquisition stopped without stop");
  a_accum_sum: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_en && !pipe_first[1] |-> wr_data == acc_rd_q
    + ACC_W'(pipe_s[1]))
    else $error("accumulation sum wrong");
  a_read_banks: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_busy && state == SAD_ACC |-> drain_bank != fill_bank)
    else $error("readout and fill share a bank");
  a_read_len: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_issue_last |=> rd_valid_o && rd_last_o ##1 !rd_valid_o)
    else $error("readout length wrong");

  c_seq_done: cover property (@(posedge clk_i) seq_done);
  c_overlap: cover property (@(posedge clk_i) rd_busy && wr_en);
  c_abort_run: cover property (@(posedge clk_i) abort_i && state == SAD_ACC);
  c_stop_done: cover property (@(posedge clk_i)
    state == SAD_REARM ##1 state == SAD_IDLE);
endmodule

// ---- sad_pkg.sv ----
package sad_pkg;
  // ------------------------------------------------------------
  // Sample and accumulator shape
  // ------------------------------------------------------------
  localparam int SAMPLE_W = 8;
  localparam int ADDR_W = 10;
  localparam int AVG_CNT_W = 16;
  localparam int ACC_W = SAMPLE_W + AVG_CNT_W;
  localparam logic [AVG_CNT_W-1:0] MIN_AVERAGES = 16'h0004;
  // ------------------------------------------------------------
  // Decimation
  // ------------------------------------------------------------
  localparam int DECIM_SEL_W = 3;
  localparam logic [DECIM_SEL_W-1:0] DECIM_SEL_MAX = 3'h5;
  localparam int DECIM_CNT_W = 5;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int REARM_TIME_NS = 100;
  localparam int REARM_CYCLES =
    (REARM_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : REARM_TIME_NS / CLK_PERIOD_NS;
  localparam int TRIG_RATE_MAX_HZ = 1000000;
  // ------------------------------------------------------------
  // Accumulator state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SAD_IDLE = 2'b00,
    SAD_WAIT = 2'b01,
    SAD_ACC  = 2'b11,
    SAD_REARM = 2'b10
  } sad_state_type;
endpackage

// ---- sad_ram.sv ----
`timescale 1ns/1ns
// Simple dual-port memory with registered read data
module sad_ram #(
  parameter int WIDTH = 24,
  parameter int DEPTH_W = 11
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [DEPTH_W-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [DEPTH_W-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [0:(1<<DEPTH_W)-1];

  // No reset on the array; contents are overwritten before use
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ---- sad_front.sv ----
`timescale 1ns/1ns
// Inversion then decimation of the incoming sample stream
module sad_front
  import sad_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sample_valid_i,
  input wire logic [sad_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic sample_invert_enable_i,
  input wire logic [sad_pkg::DECIM_SEL_W-1:0] decim_sel_i,
  output logic out_valid_o,
  output logic [sad_pkg::SAMPLE_W-1:0] out_sample_o
);
  logic [DECIM_CNT_W-1:0] phase;
  logic [DECIM_CNT_W-1:0] next_phase;
  logic [DECIM_CNT_W-1:0] ratio_m1;
  logic next_valid;
  logic [SAMPLE_W-1:0] next_sample;

  // Ratio is a power of two; over-range selects clamp to 32
  always_comb begin
    if (decim_sel_i > DECIM_SEL_MAX) begin
      ratio_m1 = DECIM_CNT_W'((1 << DECIM_SEL_MAX) - 1);
    end else begin
      ratio_m1 = DECIM_CNT_W'((1 << decim_sel_i) - 1);
    end
    next_phase = phase;
    next_valid = 1'b0;
    next_sample = out_sample_o;
    if (sample_valid_i) begin
      next_phase = (phase >= ratio_m1) ? '0 : phase + 1'b1;
      if (phase == '0) begin
        next_valid = 1'b1;
        // Inverted ahead of the accumulator
        next_sample = sample_invert_enable_i ? ~sample_i : sample_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase <= '0;
      out_valid_o <= 1'b0;
      out_sample_o <= '0;
    end else begin
      phase <= next_phase;
      out_valid_o <= next_valid;
      out_sample_o <= next_sample;
    end
  end

  a_decim_first: assert property (@(posedge clk_i) disable iff (reset_i)
    sample_valid_i && phase == '0 |=> out_valid_o)
    else $error("decimated sample not emitted");
  a_invert_path: assert property (@(posedge clk_i) disable iff (reset_i)
    sample_valid_i && phase == '0 && sample_invert_enable_i
    |=> out_sample_o == ~$past(sample_i))
    else $error("sample not inverted");
endmodule

// ---- sad_host.sv ----
`timescale 1ns/1ns
// Host side that fetches finished accumulation records after a set delay
module sad_host
  import sad_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rec_ready_i,
  input wire logic rd_valid_i,
  input wire logic [sad_pkg::ACC_W-1:0] rd_data_i,
  input wire logic rd_last_i,
  input wire logic [7:0] delay_i,
  output logic rd_req_o,
  output logic [sad_pkg::ACC_W-1:0] word_o [4],
  output int recs_o,
  output int last_idx_o
);
  import sad_pkg::*;
  int idx;
  int wait_n;
  // ------------------------------------------------------------
  // Fetch loop
  // ------------------------------------------------------------
  // A long delay leaves a record unread so the next one overruns it
  initial begin
    rd_req_o = 1'b0;
    recs_o = 0;
    last_idx_o = -1;
    forever begin
      @(posedge clk_i);
      if (reset_i === 1'b0 && rec_ready_i === 1'b1) begin
        repeat (delay_i) @(posedge clk_i);
        rd_req_o <= 1'b1;
        @(posedge clk_i);
        rd_req_o <= 1'b0;
        idx = 0;
        wait_n = 0;
        // Bounded so a silent readout cannot hang the host
        while (idx >= 0 && wait_n < 64) begin
          @(posedge clk_i);
          wait_n++;
          if (rd_valid_i === 1'b1) begin
            if (idx < 4) word_o[idx] <= rd_data_i;
            if (rd_last_i === 1'b1) begin
              last_idx_o <= idx;
              idx = -1;
            end else begin
              idx++;
            end
          end
        end
        recs_o <= recs_o + 1;
        @(posedge clk_i);
      end
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
  import sad_pkg::*;
  logic clk_i, reset_i, trigger_i, start_i, stop_i, abort_i, rd_req;
  logic inv, avg_opt, sim_opt, running, cfg_err, ready, rd_valid, rd_last;
  logic overrun, ramp;
  logic [SAMPLE_W-1:0] sample, ramp_cnt;
  logic [DECIM_SEL_W-1:0] decim;
  logic [ADDR_W-1:0] len_m1;
  logic [AVG_CNT_W-1:0] navg, done;
  logic [ACC_W-1:0] rd_data;
  logic [ACC_W-1:0] words [4];
  logic [7:0] host_delay;
  int recs, last_idx, n_fail, checks_done, cnt, sc;
  // ------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------
  // One sample clock from one shared reference
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Ramp input shows which samples the decimator keeps
  always @(posedge clk_i) ramp_cnt <= ramp_cnt + 8'h01;
  sad_top i_sad_top (.clk_i(clk_i), .reset_i(reset_i),
    .sample_valid_i(1'b1), .sample_i(ramp ? ramp_cnt : sample),
    .trigger_i(trigger_i),
    .sample_invert_enable_i(inv), .decim_sel_i(decim),
    .averaging_option_i(avg_opt), .simultaneous_readout_option_i(sim_opt),
    .record_len_m1_i(len_m1), .num_averages_i(navg), .start_i(start_i),
    .stop_i(stop_i), .abort_i(abort_i), .rd_req_i(rd_req),
    .running_o(running), .config_error_o(cfg_err), .rec_ready_o(ready),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_last_o(rd_last),
    .records_done_o(done), .overrun_o(overrun));
  sad_host i_sad_host (.clk_i(clk_i), .reset_i(reset_i),
    .rec_ready_i(ready), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .rd_last_i(rd_last), .delay_i(host_delay), .rd_req_o(rd_req),
    .word_o(words), .recs_o(recs), .last_idx_o(last_idx));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Averaging settings first, readout option one cycle later
  task automatic go(input logic comb, input logic iv, input logic [2:0] dc,
                    input logic [7:0] s, input logic [15:0] n);
    avg_opt <= 1'b1;
    inv <= iv;
    decim <= dc;
    sample <= s;
    navg <= n;
    @(posedge clk_i);
    sim_opt <= comb;
    @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  // One trigger every 20 cycles keeps the rate at 1 MHz
  task automatic fire(input int n);
    repeat (n) begin
      @(posedge clk_i);
      trigger_i <= 1'b1;
      @(posedge clk_i);
      trigger_i <= 1'b0;
      repeat (18) @(posedge clk_i);
    end
    #1;
  endtask
  task automatic pulse_stop(input logic ab);
    @(posedge clk_i);
    if (ab) abort_i <= 1'b1;
    else stop_i <= 1'b1;
    @(posedge clk_i);
    abort_i <= 1'b0;
    stop_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wait_recs(input int k);
    int t;
    t = 0;
    while (recs < k && t < 400) begin
      @(posedge clk_i);
      t++;
    end
    if (recs < k) n_fail++;
    #1;
  endtask
  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    #(50 * 20000);
    n_fail++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    n_fail = 0;
    checks_done = 0;
    reset_i = 1'b1;
    {trigger_i, start_i, stop_i, abort_i, inv, avg_opt, sim_opt} = '0;
    ramp = 1'b0;
    ramp_cnt = 8'h00;
    sample = 8'h05;
    decim = 3'h0;
    len_m1 = 10'h003;
    navg = 16'h0004;
    host_delay = 8'h00;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    // Three averages refused, four accepted in combined mode
    go(1'b1, 1'b0, 3'h0, 8'h05, 16'h0003);
    check("config_error", cfg_err, 1);
    check("running", running, 0);
    go(1'b1, 1'b0, 3'h0, 8'h05, 16'h0004);
    check("config_error", cfg_err, 0);
    check("running", running, 1);
    fire(4);
    check("records_done", done, 1);
    fire(2);
    check("host records", recs, 1);
    fire(2);
    wait_recs(2);
    for (int i = 0; i < 4; i++) check("word", words[i], 24'h000014);
    check("last index", last_idx, 3);
    check("records_done", done, 2);
    check("running", running, 1);
    // Abort in mid-sequence drops the partial record
    fire(2);
    pulse_stop(1'b1);
    check("running", running, 0);
    repeat (30) @(posedge clk_i);
    #1;
    check("rec_ready", ready, 0);
    check("records_done", done, 2);
    check("host records", recs, 2);
    // Plain averaging, inverted, decimated by two: ~f0 = 0f, sum 3c
    go(1'b0, 1'b1, 3'h1, 8'hf0, 16'h0004);
    fire(2);
    pulse_stop(1'b0);
    fire(2);
    wait_recs(3);
    for (int i = 0; i < 4; i++) check("inv word", words[i], 24'h3c);
    check("running", running, 0);
    // Slow host: second record lands on an unread one
    host_delay <= 8'hc8;
    go(1'b1, 1'b0, 3'h0, 8'h05, 16'h0004);
    fire(8);
    check("overrun", overrun, 1);
    pulse_stop(1'b1);
    host_delay <= 8'h00;
    wait_recs(4);
    check("host records", recs, 4);
    // Ramp input, two records summed: word step is twice the ratio,
    // out-of-range clamps to 32; the ratio is picked as a power of two
    ramp <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      if (s == 6) s = 7;
      sc = (s > 5) ? 5 : s;
      cnt = recs + 1;
      go(1'b0, 1'b0, s[2:0], 8'h00, 16'h0002);
      repeat (2) begin
        fire(1);
        repeat (4 << sc) @(posedge clk_i);
      end
      wait_recs(cnt);
      check("decim step", 8'(words[1]-words[0]), 8'(2 << sc));
      pulse_stop(1'b1);
    end
    ramp <= 1'b0;
    // Single record, inverted, no decimation
    cnt = recs + 1;
    go(1'b0, 1'b1, 3'h0, 8'h3c, 16'h0001);
    fire(1);
    wait_recs(cnt);
    check("inverted sample", words[0], 24'h0000c3);
    pulse_stop(1'b1);
    end_of_test();
  end
endmodule
